/* File: rtl/eqr_pkg.sv */
// Package: constants and types for the error queue reporter
package eqr_pkg;
  // ---------------------------------------------------------------
  // Queue shape
  // ---------------------------------------------------------------
  localparam int EQR_DEPTH = 20;
  localparam int EQR_PTR_W = 5;
  localparam int EQR_CNT_W = 5;
  localparam int EQR_CODE_W = 16;
  localparam logic [EQR_PTR_W-1:0] EQR_PTR_LAST = 5'h14 - 5'h01;
  localparam logic [EQR_PTR_W-1:0] EQR_PTR_ONE = 5'h01;
  localparam logic [EQR_PTR_W-1:0] EQR_PTR_ZERO = 5'h00;
  localparam logic [EQR_CNT_W-1:0] EQR_CNT_FULL = 5'h14;
  localparam logic [EQR_CNT_W-1:0] EQR_CNT_ONE = 5'h01;
  localparam logic [EQR_CNT_W-1:0] EQR_CNT_ZERO = 5'h00;

  // ---------------------------------------------------------------
  // Error codes (signed 16-bit)
  // ---------------------------------------------------------------
  localparam logic signed [15:0] EQR_CODE_NONE = 16'sh0000;
  localparam logic signed [15:0] EQR_CODE_OVERFLOW = -16'sh015e;
  localparam logic signed [15:0] EQR_CODE_FRONT_PANEL = 16'sh0259;
  localparam logic signed [15:0] EQR_CODE_INPUT_OPEN = 16'sh025a;
  localparam logic signed [15:0] EQR_CODE_ADC_OFFSET = 16'sh025b;
  localparam logic signed [15:0] EQR_CODE_RUNDOWN_NOISE = 16'sh025f;
  localparam logic signed [15:0] EQR_CODE_GAIN_X1 = 16'sh0261;
  localparam logic signed [15:0] EQR_CODE_GAIN_X10 = 16'sh0262;
  localparam logic signed [15:0] EQR_CODE_SENSE_HIGH_ZERO = 16'sh0265;
  localparam logic signed [15:0] EQR_CODE_INPUT_ZERO = 16'sh0266;
  localparam logic signed [15:0] EQR_CODE_CURRENT_SENSE = 16'sh0268;

  // ---------------------------------------------------------------
  // Self-test failure bits
  // ---------------------------------------------------------------
  localparam int EQR_ST_N = 9;
  localparam int EQR_ST_IDX_W = 4;
  localparam logic [EQR_ST_IDX_W-1:0] EQR_ST_IDX_ZERO = 4'h0;
  localparam logic [EQR_ST_IDX_W-1:0] EQR_ST_IDX_ONE = 4'h1;
  localparam logic [EQR_ST_N-1:0] EQR_ST_NONE = 9'h000;

  typedef enum logic [1:0] {
    EQR_ST_IDLE = 2'b01,
    EQR_ST_PUSH = 2'b10
  } eqr_st_state_t;

  function automatic logic signed [15:0] eqr_st_code(input logic [EQR_ST_IDX_W-1:0] idx);
    case (idx)
      4'h0: eqr_st_code = EQR_CODE_FRONT_PANEL;
      4'h1: eqr_st_code = EQR_CODE_INPUT_OPEN;
      4'h2: eqr_st_code = EQR_CODE_ADC_OFFSET;
      4'h3: eqr_st_code = EQR_CODE_RUNDOWN_NOISE;
      4'h4: eqr_st_code = EQR_CODE_GAIN_X1;
      4'h5: eqr_st_code = EQR_CODE_GAIN_X10;
      4'h6: eqr_st_code = EQR_CODE_SENSE_HIGH_ZERO;
      4'h7: eqr_st_code = EQR_CODE_INPUT_ZERO;
      default: eqr_st_code = EQR_CODE_CURRENT_SENSE;
    endcase
  endfunction : eqr_st_code
endpackage : eqr_pkg

/* File: rtl/eqr_selftest_sequencer.sv */
// Self-test result sequencer: turns a fail vector into queued error codes
`timescale 1ns/10ps
module eqr_selftest_sequencer
  import eqr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic [EQR_ST_N-1:0] selftest_fail_bits,
  output logic st_push,
  output logic signed [EQR_CODE_W-1:0] st_code,
  output logic st_busy
);
  eqr_st_state_t state_ff, nxt_state;
  logic [EQR_ST_N-1:0] pend_ff, nxt_pend;
  logic [EQR_ST_IDX_W-1:0] idx_ff, nxt_idx;

  // ---------------------------------------------------------------
  // Walk pending fail bits, one code per cycle
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    nxt_idx = idx_ff;
    st_push = 1'b0;
    st_code = eqr_st_code(idx_ff);
    case (state_ff)
      EQR_ST_IDLE: begin
        if (selftest_done && selftest_fail && (selftest_fail_bits != EQR_ST_NONE)) begin
          nxt_pend = selftest_fail_bits;
          nxt_idx = EQR_ST_IDX_ZERO;
          nxt_state = EQR_ST_PUSH;
        end
      end
      EQR_ST_PUSH: begin
        if (pend_ff[idx_ff]) begin
          st_push = 1'b1;
          nxt_pend[idx_ff] = 1'b0;
        end
        if (idx_ff == EQR_ST_IDX_W'(EQR_ST_N - 1)) begin
          nxt_state = EQR_ST_IDLE;
        end else begin
          nxt_idx = idx_ff + EQR_ST_IDX_ONE;
        end
      end
      default: nxt_state = EQR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= EQR_ST_IDLE;
      pend_ff <= EQR_ST_NONE;
      idx_ff <= EQR_ST_IDX_ZERO;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      idx_ff <= nxt_idx;
    end
  end

  assign st_busy = (state_ff == EQR_ST_PUSH);
endmodule : eqr_selftest_sequencer

/* File: rtl/eqr_error_queue_reporter.sv */
// Error queue reporter: 20-entry FIFO of signed error codes with indicator
`timescale 1ns/10ps
// What this block does
// - Queue holds at most 20 codes; each new error takes next free entry, except an external one meeting a self-test push.
// - Codes are read out strictly oldest first.
// - Error indicator is lit while any recorded error remains unread.
// - Indicator goes dark once the reader has drained the queue.
// - Reading an empty queue returns a distinct no-error answer.
// - Error into a full queue overwrites newest entry with -350; new error lost.
// - Queue empties at power-up and on clear-status command.
// - General instrument reset leaves queue contents untouched.
// - Failed self-test with any fail bit set lights indicator and pushes its error codes.
// - Codes 601 front panel, 602 inputs not open, 603 converter offset.
// - Codes 607 noisy rundown, 610 gain ten path, 616 current check.
// - Codes 609 unity gain path, 613 sense-high zero, 614 input zero.
module eqr_error_queue_reporter
  import eqr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clear_status,
  input wire logic instrument_reset,
  input wire logic err_push,
  input wire logic signed [EQR_CODE_W-1:0] err_code,
  input wire logic read_strobe,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic [EQR_ST_N-1:0] selftest_fail_bits,
  output logic signed [EQR_CODE_W-1:0] read_code_ff,
  output logic read_valid_ff,
  output logic read_empty_ff,
  output logic error_indicator_ff,
  output logic [EQR_CNT_W-1:0] count_ff,
  output logic full_ff,
  output logic selftest_busy_ff
);
  // Queue storage and pointers
  logic signed [EQR_CODE_W-1:0] mem_ff [EQR_DEPTH];
  logic signed [EQR_CODE_W-1:0] nxt_mem [EQR_DEPTH];
  logic [EQR_PTR_W-1:0] rd_ptr_ff;
  logic [EQR_PTR_W-1:0] nxt_rd_ptr;
  logic [EQR_PTR_W-1:0] wr_ptr_ff;
  logic [EQR_PTR_W-1:0] nxt_wr_ptr;
  logic [EQR_CNT_W-1:0] nxt_count;
  logic signed [EQR_CODE_W-1:0] nxt_read_code;
  logic nxt_read_valid;
  logic nxt_read_empty;
  logic nxt_error_indicator;
  logic nxt_full;
  logic nxt_selftest_busy;
  // Self-test side
  logic st_push;
  logic st_busy;
  logic signed [EQR_CODE_W-1:0] st_code;
  logic any_push;
  logic signed [EQR_CODE_W-1:0] push_code;
  logic wr_take;
  logic ovf_take;
  logic [EQR_CNT_W-1:0] cnt_after_rd;
  logic [EQR_PTR_W-1:0] last_ptr;

  // ---------------------------------------------------------------
  // Self-test code source
  // ---------------------------------------------------------------
  eqr_selftest_sequencer u_selftest (
    .clock(clock),
    .reset(reset),
    .selftest_done(selftest_done),
    .selftest_fail(selftest_fail),
    .selftest_fail_bits(selftest_fail_bits),
    .st_push(st_push),
    .st_code(st_code),
    .st_busy(st_busy)
  );

  function automatic logic [EQR_PTR_W-1:0] ptr_inc(input logic [EQR_PTR_W-1:0] p);
    ptr_inc = (p == EQR_PTR_LAST) ? EQR_PTR_ZERO : p + EQR_PTR_ONE;
  endfunction : ptr_inc

  // ---------------------------------------------------------------
  // Pointer step back, for the overflow overwrite
  // ---------------------------------------------------------------
  function automatic logic [EQR_PTR_W-1:0] ptr_dec(input logic [EQR_PTR_W-1:0] p);
    ptr_dec = (p == EQR_PTR_ZERO) ? EQR_PTR_LAST : p - EQR_PTR_ONE;
  endfunction : ptr_dec

  // ---------------------------------------------------------------
  // Push arbitration
  // ---------------------------------------------------------------
  always_comb begin
    // Both sources share one write port into the queue
    // Self-test codes take priority; an external error meanwhile is dropped
    any_push = st_push | err_push;
    push_code = st_push ? st_code : err_code;
  end

  // ---------------------------------------------------------------
  // Read side: pointer, answer and flags of the last read
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rd_ptr = rd_ptr_ff;
    nxt_read_code = read_code_ff;
    nxt_read_valid = 1'b0;
    nxt_read_empty = read_empty_ff;
    cnt_after_rd = count_ff;
    // Answer stands until the next strobe; valid lasts one cycle
    if (read_strobe) begin
      nxt_read_valid = 1'b1;
      if (count_ff == EQR_CNT_ZERO) begin
        // Empty queue: answer with the no-error code, remove nothing
        nxt_read_code = EQR_CODE_NONE;
        nxt_read_empty = 1'b1;
      end else begin
        nxt_read_code = mem_ff[rd_ptr_ff];
        nxt_read_empty = 1'b0;
        nxt_rd_ptr = ptr_inc(rd_ptr_ff);
        cnt_after_rd = count_ff - EQR_CNT_ONE;
      end
    end
    // Clear-status restarts both pointers at entry zero
    if (clear_status) begin
      nxt_rd_ptr = EQR_PTR_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ptr_ff <= EQR_PTR_ZERO;
      read_code_ff <= EQR_CODE_NONE;
      read_valid_ff <= 1'b0;
      read_empty_ff <= 1'b1;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      read_code_ff <= nxt_read_code;
      read_valid_ff <= nxt_read_valid;
      read_empty_ff <= nxt_read_empty;
    end
  end

  // ---------------------------------------------------------------
  // Write side: pointer and count
  // ---------------------------------------------------------------
  always_comb begin
    wr_take = 1'b0;
    ovf_take = 1'b0;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_count = cnt_after_rd;
    last_ptr = ptr_dec(wr_ptr_ff);
    // Read is settled first, so a push sees the freed slot
    if (any_push) begin
      if (cnt_after_rd == EQR_CNT_FULL) begin
        // Full: count stays, the newest entry takes the overflow code
        ovf_take = 1'b1;
      end else begin
        wr_take = 1'b1;
        nxt_wr_ptr = ptr_inc(wr_ptr_ff);
        nxt_count = cnt_after_rd + EQR_CNT_ONE;
      end
    end
    // Clear-status empties the queue; instrument_reset deliberately has no effect
    if (clear_status) begin
      nxt_wr_ptr = EQR_PTR_ZERO;
      nxt_count = EQR_CNT_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_ff <= EQR_PTR_ZERO;
      count_ff <= EQR_CNT_ZERO;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      count_ff <= nxt_count;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_comb begin
    // Indicator follows the count, so self-test codes light it as well
    nxt_error_indicator = (nxt_count != EQR_CNT_ZERO);
    nxt_full = (nxt_count == EQR_CNT_FULL);
    nxt_selftest_busy = st_busy;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      error_indicator_ff <= 1'b0;
      full_ff <= 1'b0;
      selftest_busy_ff <= 1'b0;
    end else begin
      error_indicator_ff <= nxt_error_indicator;
      full_ff <= nxt_full;
      selftest_busy_ff <= nxt_selftest_busy;
    end
  end

  // ---------------------------------------------------------------
  // Storage: one slice per entry
  // ---------------------------------------------------------------
  // No reset here: only the count_ff entries starting at rd_ptr_ff are ever read
  for (genvar g = 0; g < EQR_DEPTH; g++) begin : g_entry
    logic hit_wr;
    logic hit_ovf;
    always_comb begin
      // At most one of the two hits is set in any cycle
      hit_wr = wr_take && (wr_ptr_ff == EQR_PTR_W'(g));
      hit_ovf = ovf_take && (last_ptr == EQR_PTR_W'(g));
      nxt_mem[g] = mem_ff[g];
      if (hit_ovf) begin
        nxt_mem[g] = EQR_CODE_OVERFLOW;
      end else if (hit_wr) begin
        nxt_mem[g] = push_code;
      end
    end

    always_ff @(posedge clock) begin
      mem_ff[g] <= nxt_mem[g];
    end
  end
endmodule : eqr_error_queue_reporter

/* File: verification/eqr_error_queue_reporter_checker.sv */
// Checker: port-level properties of the error queue reporter
`timescale 1ns/10ps
module eqr_error_queue_reporter_checker
  import eqr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clear_status,
  input wire logic instrument_reset,
  input wire logic err_push,
  input wire logic signed [EQR_CODE_W-1:0] err_code,
  input wire logic read_strobe,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic [EQR_ST_N-1:0] selftest_fail_bits,
  input wire logic signed [EQR_CODE_W-1:0] read_code_ff,
  input wire logic read_valid_ff,
  input wire logic read_empty_ff,
  input wire logic error_indicator_ff,
  input wire logic [EQR_CNT_W-1:0] count_ff,
  input wire logic full_ff,
  input wire logic selftest_busy_ff
);
  // Self-test pushes start before busy shows, so count edges are judged away from them
  logic [1:0] done_d_ff;
  logic [1:0] nxt_done_d;
  logic quiet;
  always_comb begin
    nxt_done_d = {done_d_ff[0], selftest_done};
  end
  always_ff @(posedge clock) begin
    done_d_ff <= reset ? 2'h0 : nxt_done_d;
  end
  assign quiet = !clear_status && !selftest_done && done_d_ff == 2'h0 && !selftest_busy_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_room; err_push && !read_strobe && quiet && !full_ff; endsequence
  sequence s_over; err_push && !read_strobe && quiet && full_ff; endsequence
  property p_valid; read_strobe |=> read_valid_ff; endproperty
  property p_empty; read_strobe && count_ff == EQR_CNT_ZERO
    |=> read_empty_ff && read_code_ff == EQR_CODE_NONE; endproperty
  property p_ind; error_indicator_ff == (count_ff != EQR_CNT_ZERO); endproperty
  property p_full; full_ff == (count_ff == EQR_CNT_FULL); endproperty
  property p_max; count_ff <= EQR_CNT_FULL; endproperty
  property p_clr; clear_status |=> count_ff == EQR_CNT_ZERO && !error_indicator_ff; endproperty
  property p_push; s_room |=> count_ff == $past(count_ff) + EQR_CNT_ONE; endproperty
  property p_ovf; s_over |=> full_ff; endproperty
  property p_pop; read_strobe && !err_push && quiet && count_ff != EQR_CNT_ZERO
    |=> count_ff == $past(count_ff) - EQR_CNT_ONE; endproperty
  property p_both; read_strobe && err_push && quiet && full_ff |=> full_ff; endproperty
  sequence s_st_start; selftest_done && selftest_fail && selftest_fail_bits != EQR_ST_NONE
    && !selftest_busy_ff && done_d_ff == 2'h0; endsequence
  property p_busy; s_st_start |=> ##1 selftest_busy_ff; endproperty
  property p_one; !read_strobe |=> !read_valid_ff; endproperty
  property p_keep; instrument_reset && !err_push && !read_strobe && quiet
    |=> count_ff == $past(count_ff); endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  a_empty: assert property (p_empty) else $error("empty read wrong");
  a_ind: assert property (p_ind) else $error("indicator wrong");
  a_full: assert property (p_full) else $error("full flag wrong");
  a_max: assert property (p_max) else $error("count too big");
  a_clr: assert property (p_clr) else $error("clear failed");
  a_push: assert property (p_push) else $error("push not counted");
  a_ovf: assert property (p_ovf) else $error("overflow lost full");
  a_pop: assert property (p_pop) else $error("read not removed");
  a_both: assert property (p_both) else $error("read then push wrong");
  a_busy: assert property (p_busy) else $error("self-test not started");
  a_one: assert property (p_one) else $error("valid without read");
  a_keep: assert property (p_keep) else $error("general reset touched queue");
endmodule : eqr_error_queue_reporter_checker

/* File: verification/eqr_reader_model.sv */
// Reader model: issues one read strobe per requested read
`timescale 1ns/10ps
module eqr_reader_model (
  input wire logic clock,
  output logic read_strobe
);
  initial read_strobe = 1'b0;
  // Waits gap plus one falling edges, then one strobe lasting one cycle
  task automatic read_one(input int gap);
    repeat (gap) @(negedge clock);
    @(negedge clock);
    read_strobe = 1'b1;
    @(negedge clock);
    read_strobe = 1'b0;
  endtask : read_one
endmodule : eqr_reader_model

/* File: verification/eqr_error_queue_reporter_test.sv */
// Testbench: random and corner tests of the error queue reporter
`timescale 1ns/10ps
module eqr_error_queue_reporter_test
  import eqr_pkg::*;
;
  logic clock, reset, clear_status, instrument_reset, err_push, selftest_done, selftest_fail;
  logic signed [EQR_CODE_W-1:0] err_code, read_code_ff;
  logic [EQR_ST_N-1:0] selftest_fail_bits;
  logic read_strobe, read_valid_ff, read_empty_ff, error_indicator_ff, full_ff, selftest_busy_ff;
  logic [EQR_CNT_W-1:0] count_ff;
  int failures = 0;
  int n_compared = 0;
  logic signed [15:0] q[$];
  logic [15:0] lfsr = 16'h002e;
  logic signed [15:0] st_codes [9] = '{16'sh0259, 16'sh025a, 16'sh025b, 16'sh025f,
    16'sh0261, 16'sh0262, 16'sh0265, 16'sh0266, 16'sh0268};
  eqr_error_queue_reporter i_eqr_error_queue_reporter (.clock, .reset, .clear_status,
    .instrument_reset, .err_push, .err_code, .read_strobe, .selftest_done, .selftest_fail,
    .selftest_fail_bits, .read_code_ff, .read_valid_ff, .read_empty_ff, .error_indicator_ff,
    .count_ff, .full_ff, .selftest_busy_ff);
  eqr_reader_model i_eqr_reader_model (.clock, .read_strobe);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic state();
    chk(count_ff === EQR_CNT_W'(q.size()), "count");
    chk(error_indicator_ff === (q.size() != 0), "indicator");
    chk(full_ff === (q.size() == EQR_DEPTH), "full");
  endtask : state
  task automatic push(input logic signed [15:0] c);
    @(negedge clock);
    err_push = 1'b1;
    err_code = c;
    @(negedge clock);
    err_push = 1'b0;
    if (q.size() < EQR_DEPTH) q.push_back(c);
    else q[$] = EQR_CODE_OVERFLOW;
  endtask : push
  task automatic push_rnd(input int n);
    repeat (n) begin
      lfsr = lfsr_next(lfsr);
      push(lfsr);
    end
  endtask : push_rnd
  task automatic rd(input int gap);
    logic emp;
    logic signed [15:0] e;
    emp = (q.size() == 0);
    e = emp ? EQR_CODE_NONE : q.pop_front();
    i_eqr_reader_model.read_one(gap);
    chk(read_valid_ff === 1'b1, "valid");
    chk(read_code_ff === e, "code order");
    chk(read_empty_ff === emp, "empty flag");
  endtask : rd
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    {reset, clear_status, instrument_reset, err_push, selftest_done, selftest_fail} = 6'h01 << 5;
    err_code = 16'sh0000;
    selftest_fail_bits = 9'h000;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    push_rnd(25);
    state();
    for (int i = 0; i < 21; i++) rd(i % 3);
    state();
    $display("fill, overflow and drain done");
    push_rnd(20);
    fork
      rd(0);
      push(16'sh0123);
    join
    state();
    repeat (20) rd(0);
    $display("read with push at full done");
    push_rnd(3);
    @(negedge clock) instrument_reset = 1'b1;
    @(negedge clock) instrument_reset = 1'b0;
    state();
    @(negedge clock) clear_status = 1'b1;
    @(negedge clock) clear_status = 1'b0;
    q.delete();
    state();
    rd(1);
    $display("resets done");
    for (int r = 0; r < 2; r++) begin
      lfsr = lfsr_next(lfsr);
      @(negedge clock);
      {selftest_done, selftest_fail} = 2'h3;
      selftest_fail_bits = r ? (lfsr[8:0] | 9'h001) : 9'h1ff;
      @(negedge clock);
      {selftest_done, selftest_fail} = 2'h0;
      for (int k = 0; k < 9; k++) if (selftest_fail_bits[k]) q.push_back(st_codes[k]);
      @(negedge clock);
      chk(selftest_busy_ff === 1'b1, "busy");
      repeat (11) @(negedge clock);
      chk(selftest_busy_ff === 1'b0, "idle");
      state();
      while (q.size() > 0) rd(0);
    end
    $display("self-test codes done");
    @(negedge clock);
    {selftest_done, selftest_fail} = 2'h2;
    selftest_fail_bits = 9'h1ff;
    @(negedge clock);
    {selftest_done, selftest_fail} = 2'h3;
    selftest_fail_bits = 9'h000;
    @(negedge clock);
    {selftest_done, selftest_fail} = 2'h0;
    repeat (12) @(negedge clock);
    state();
    push_rnd(4);
    @(negedge clock) reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    q.delete();
    state();
    chk(read_empty_ff === 1'b1 && read_code_ff === EQR_CODE_NONE, "reset answer");
    rd(0);
    $display("pass result and reset done");
    print_verdict();
  end
endmodule : eqr_error_queue_reporter_test
bind eqr_error_queue_reporter eqr_error_queue_reporter_checker i_eqr_error_queue_reporter_checker (
  .clock, .reset, .clear_status, .instrument_reset, .err_push, .err_code, .read_strobe,
  .selftest_done, .selftest_fail, .selftest_fail_bits, .read_code_ff, .read_valid_ff,
  .read_empty_ff, .error_indicator_ff, .count_ff, .full_ff, .selftest_busy_ff);
